// ---- inc/exc_pkg.sv ----
// Constants, types and helpers shared by the exception and reset unit.
// Assumes a single 100 MHz processor clock for all of its users.
package exc_pkg;

  // ---------------------------------------------------------------
  // Register indices on the plain register port
  // ---------------------------------------------------------------
  localparam logic [3:0] A_STATUS = 4'h0;
  localparam logic [3:0] A_IP = 4'h1;
  localparam logic [3:0] A_CS = 4'h2;
  localparam logic [3:0] A_DS = 4'h3;
  localparam logic [3:0] A_ES = 4'h4;
  localparam logic [3:0] A_SS = 4'h5;
  localparam logic [3:0] A_RELOC = 4'h6;
  localparam logic [3:0] A_UMSEL = 4'h7;
  localparam logic [3:0] A_PRIO_A = 4'h8;
  localparam logic [3:0] A_PRIO_B = 4'h9;
  localparam logic [3:0] A_VBASE = 4'ha;
  localparam logic [3:0] A_VTYPE = 4'hb;
  localparam logic [3:0] A_PEND = 4'hc;

  // ---------------------------------------------------------------
  // Reset values and field positions
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_STATUS = 16'hf002;
  localparam logic [15:0] RST_CS = 16'hffff;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [15:0] RST_RELOC = 16'h20ff;
  localparam logic [15:0] RST_UMSEL = 16'hfffb;
  localparam int STEP_BIT = 8;
  localparam int IF_BIT = 9;
  localparam int OF_BIT = 11;
  localparam int SLAVE_BIT = 15;
  localparam logic [15:0] SW_CLR_MASK = 16'h0300;
  localparam logic [4:0] COP_HI = 5'h1b;
  localparam logic [19:0] RESTART_ADDR = 20'hffff0;

  // ---------------------------------------------------------------
  // Vector types
  // ---------------------------------------------------------------
  localparam logic [7:0] VT_QUOT = 8'h00;
  localparam logic [7:0] VT_STEP = 8'h01;
  localparam logic [7:0] VT_NMI = 8'h02;
  localparam logic [7:0] VT_BRK = 8'h03;
  localparam logic [7:0] VT_OVF = 8'h04;
  localparam logic [7:0] VT_BOUND = 8'h05;
  localparam logic [7:0] VT_UNDEF = 8'h06;
  localparam logic [7:0] VT_COP = 8'h07;
  localparam logic [7:0] VT_TMR0 = 8'h08;
  localparam logic [7:0] VT_TMR1 = 8'h12;
  localparam logic [7:0] VT_TMR2 = 8'h13;
  localparam logic [7:0] VT_DMA0 = 8'h0a;
  localparam logic [7:0] VT_DMA1 = 8'h0b;
  localparam logic [7:0] VT_EXT0 = 8'h0c;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_NS = 10;
  localparam int RST_DELAY_NS = 60;
  localparam logic [3:0] RST_DELAY_CYC = 4'((RST_DELAY_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_RUN = 3'b001,
    ST_PUSH_SW = 3'b010,
    ST_PUSH_CS = 3'b011,
    ST_PUSH_IP = 3'b100,
    ST_VECTOR = 3'b101
  } seq_t;

  function automatic logic [9:0] vec_addr(input logic [7:0] vt);
    vec_addr = {vt, 2'b00};
  endfunction : vec_addr

endpackage : exc_pkg

// ---- inc/irq_arb_if.sv ----
// Signals between the sequencer and the maskable request arbiter.
// Assumes both ends run on the processor clock.
`timescale 1ns/1ps
interface irq_arb_if;
  logic [6:0] pend;
  logic [2:0] tmr_pend;
  logic [20:0] lvl;
  logic slave;
  logic [15:0] vbase;
  logic hit;
  logic [7:0] vtype;
  logic [8:0] ack;
  modport core (output pend, tmr_pend, lvl, slave, vbase, input hit, vtype, ack);
  modport arb (input pend, tmr_pend, lvl, slave, vbase, output hit, vtype, ack);
endinterface : irq_arb_if

// ---- rtl/pin_sync.sv ----
// Two-flop synchroniser for pin inputs.
// Assumes the pins are asynchronous to core_clk_i.
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 5
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;
  sync_t s, n;

  always_comb begin
    n.s1 = d_i;
    n.s2 = s.s1;
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s <= '0;
    end else if (ce_i) begin
      s <= n;
    end
  end

  assign q_o = s.s2;
endmodule : pin_sync

// ---- rtl/maskable_arbiter.sv ----
// Picks the maskable request to serve and its vector type.
// Assumes request levels are already on the processor clock.
`timescale 1ns/1ps
module maskable_arbiter import exc_pkg::*; (
  irq_arb_if.arb bus
);
  function automatic logic all_unique(input logic [20:0] l);
    all_unique = 1'b1;
    for (int i = 0; i < 7; i++) begin
      for (int j = i + 1; j < 7; j++) begin
        if (l[3*i +: 3] == l[3*j +: 3]) begin
          all_unique = 1'b0;
        end
      end
    end
  endfunction : all_unique

  logic uniq;
  logic [2:0] best;
  logic [2:0] best_lvl;

  // Programmed levels only count once every source has its own level.
  always_comb begin
    uniq = all_unique(bus.lvl);
    best = 3'd0;
    best_lvl = 3'd7;
    bus.hit = 1'b0;
    bus.vtype = 8'h00;
    bus.ack = '0;
    for (int i = 6; i >= 0; i--) begin
      if (bus.pend[i] && (!uniq || bus.lvl[3*i +: 3] <= best_lvl || !bus.hit)) begin
        if (!bus.hit || !uniq || bus.lvl[3*i +: 3] <= best_lvl) begin
          best = 3'(i);
          best_lvl = bus.lvl[3*i +: 3];
          bus.hit = 1'b1;
        end
      end
    end
    if (bus.hit) begin
      case (best)
        3'd0: begin
          // Timers share one level; timer 0 wins over 1, and 1 over 2.
          if (bus.tmr_pend[0]) begin
            bus.vtype = bus.slave ? bus.vbase[7:0] : VT_TMR0;
            bus.ack[0] = 1'b1;
          end else if (bus.tmr_pend[1]) begin
            bus.vtype = bus.slave ? 8'(bus.vbase[7:0] + 8'h01) : VT_TMR1;
            bus.ack[1] = 1'b1;
          end else begin
            bus.vtype = bus.slave ? 8'(bus.vbase[7:0] + 8'h02) : VT_TMR2;
            bus.ack[2] = 1'b1;
          end
        end
        3'd1: begin
          bus.vtype = bus.slave ? bus.vbase[15:8] : VT_DMA0;
          bus.ack[3] = 1'b1;
        end
        3'd2: begin
          bus.vtype = bus.slave ? 8'(bus.vbase[15:8] + 8'h01) : VT_DMA1;
          bus.ack[4] = 1'b1;
        end
        default: begin
          bus.vtype = 8'(VT_EXT0 + 8'(best - 3'd3));
          bus.ack[5 + 32'(best - 3'd3)] = 1'b1;
        end
      endcase
    end
  end
endmodule : maskable_arbiter

// ---- rtl/cpu_exception_vector_reset_unit.sv ----
// Exception, interrupt entry and reset sequencer of the processor core.
// Assumes the core pulses instr_done_i at each instruction boundary
// and waits while run_o is low.
//
// What this block does
// - Single step traps type 1, except listed instructions.
// - Step entry clears step flag; return restores it.
// - NMI is type 2, unmasked, no acknowledge.
// - NMI entry clears the enable flag.
// - Breakpoint is type 3, table index 12.
// - Overflow trap type 4 only if overflow.
// - Range check out of bounds traps type 5.
// - Undefined opcode traps type 6.
// - Escape opcodes always trap type 7.
// - Escape return points at escape or prefix.
// - Pins, DMA, timers accepted only when enabled.
// - Entry clears enable flag after saving status.
// - Return re-enabling serves pending request first.
// - Timers share level, order 0,1,2; types 8,18,19.
// - Default priority unless levels unique; fixed types.
// - Slave mode makes timer, DMA types programmable.
// - Reset stops all execution and bus activity.
// - After reset delay fetch from FFFF0.
// - Reset loads status, segments, pointer values.
// - Reset loads relocation and upper select values.
// - Vector read at type times four.
// - Hardware requests sampled at instruction boundaries.
// - Entry pushes status, code segment, pointer.
// - Divide overflow traps type 0.
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
module cpu_exception_vector_reset_unit import exc_pkg::*; (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  input wire logic nmi_pin_i,
  input wire logic [3:0] ext_request_pins_i,
  input wire logic [2:0] tmr_req_i,
  input wire logic [1:0] dma_req_i,
  output logic [8:0] src_ack_o,
  input wire logic instr_done_i,
  input wire logic prefix_i,
  input wire logic seg_write_i,
  input wire logic wait_i,
  input wire logic [7:0] opcode_i,
  input wire logic undef_i,
  input wire logic brk_i,
  input wire logic ovf_trap_i,
  input wire logic range_chk_i,
  input wire logic [15:0] index_i,
  input wire logic [15:0] bound_lo_i,
  input wire logic [15:0] bound_hi_i,
  input wire logic quot_ovf_i,
  input wire logic seg_prefix_i,
  input wire logic ret_instr_i,
  input wire logic [15:0] ret_sw_i,
  input wire logic [15:0] instr_ip_i,
  input wire logic [15:0] prefix_ip_i,
  input wire logic [15:0] next_ip_i,
  output logic run_o,
  output logic push_o,
  output logic [15:0] push_data_o,
  output logic vec_req_o,
  output logic [9:0] vec_addr_o,
  output logic [7:0] vec_type_o,
  output logic fetch_req_o,
  output logic [19:0] fetch_addr_o
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    seq_t st;
    logic [3:0] cnt;
    logic [15:0] sw;
    logic [15:0] ip;
    logic [15:0] cs;
    logic [15:0] ds;
    logic [15:0] es;
    logic [15:0] ss;
    logic [15:0] reloc;
    logic [15:0] umsel;
    logic [15:0] prio_a;
    logic [15:0] prio_b;
    logic [15:0] vbase;
    logic [15:0] saved_sw;
    logic [15:0] ret_ip;
    logic [15:0] pdata;
    logic [15:0] rdata;
    logic [7:0] vtype;
    logic nmi_prev;
    logic nmi_pend;
    logic push;
    logic vreq;
    logic freq;
    logic [8:0] ack;
  } state_t;

  localparam state_t RST_STATE = '{
    st: ST_RESET, cnt: 4'h0, sw: RST_STATUS, ip: RST_ZERO, cs: RST_CS,
    ds: RST_ZERO, es: RST_ZERO, ss: RST_ZERO, reloc: RST_RELOC,
    umsel: RST_UMSEL, prio_a: RST_ZERO, prio_b: RST_ZERO, vbase: RST_ZERO,
    saved_sw: RST_ZERO, ret_ip: RST_ZERO, pdata: RST_ZERO, rdata: RST_ZERO,
    vtype: 8'h00, nmi_prev: 1'b0, nmi_pend: 1'b0, push: 1'b0, vreq: 1'b0,
    freq: 1'b0, ack: 9'h000
  };

  state_t s, n;
  logic [4:0] pins_s;
  logic nmi_edge;
  logic boundary;
  logic cop_op;
  logic bound_bad;
  logic exc;
  logic step;
  logic take_irq;
  logic [15:0] nsw;
  logic [7:0] exc_type;

  irq_arb_if arb();

  // The pins come from outside; timer and DMA requests are on-chip.
  pin_sync #(.W(5)) u_sync (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .d_i({nmi_pin_i, ext_request_pins_i}),
    .q_o(pins_s)
  );

  maskable_arbiter u_arb (
    .bus(arb.arb)
  );

  assign arb.pend = {pins_s[3:0], dma_req_i, |tmr_req_i};
  assign arb.tmr_pend = tmr_req_i;
  assign arb.lvl = {s.prio_b[8:0], s.prio_a[11:0]};
  assign arb.slave = s.prio_b[SLAVE_BIT];
  assign arb.vbase = s.vbase;

  function automatic logic out_of_range(input logic [15:0] i, input logic [15:0] lo,
                                        input logic [15:0] hi);
    out_of_range = ($signed(i) < $signed(lo)) || ($signed(i) > $signed(hi));
  endfunction : out_of_range

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    n = s;
    n.push = 1'b0;
    n.vreq = 1'b0;
    n.freq = 1'b0;
    n.ack = '0;
    n.rdata = '0;
    nmi_edge = pins_s[4] & ~s.nmi_prev;
    n.nmi_prev = pins_s[4];
    if (nmi_edge) begin
      n.nmi_pend = 1'b1;
    end
    boundary = (s.st == ST_RUN) && instr_done_i;
    cop_op = opcode_i[7:3] == COP_HI;
    bound_bad = range_chk_i && out_of_range(index_i, bound_lo_i, bound_hi_i);
    exc = quot_ovf_i | undef_i | cop_op | bound_bad | (ovf_trap_i & s.sw[OF_BIT]) | brk_i;
    if (quot_ovf_i) begin
      exc_type = VT_QUOT;
    end else if (undef_i) begin
      exc_type = VT_UNDEF;
    end else if (cop_op) begin
      exc_type = VT_COP;
    end else if (bound_bad) begin
      exc_type = VT_BOUND;
    end else if (ovf_trap_i && s.sw[OF_BIT]) begin
      exc_type = VT_OVF;
    end else begin
      exc_type = VT_BRK;
    end
    // The step check uses the flag in force before this instruction.
    step = s.sw[STEP_BIT] & ~prefix_i & ~seg_write_i & ~wait_i;
    nsw = ret_instr_i ? ret_sw_i : s.sw;
    take_irq = arb.hit & nsw[IF_BIT];

    if (reg_wr_i) begin
      case (reg_addr_i)
        A_STATUS: n.sw = reg_wdata_i;
        A_IP: n.ip = reg_wdata_i;
        A_CS: n.cs = reg_wdata_i;
        A_DS: n.ds = reg_wdata_i;
        A_ES: n.es = reg_wdata_i;
        A_SS: n.ss = reg_wdata_i;
        A_RELOC: n.reloc = reg_wdata_i;
        A_UMSEL: n.umsel = reg_wdata_i;
        A_PRIO_A: n.prio_a = {4'h0, reg_wdata_i[11:0]};
        A_PRIO_B: n.prio_b = {reg_wdata_i[15], 6'h00, reg_wdata_i[8:0]};
        A_VBASE: n.vbase = reg_wdata_i;
        default: n.rdata = '0;
      endcase
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        A_STATUS: n.rdata = s.sw;
        A_IP: n.rdata = s.ip;
        A_CS: n.rdata = s.cs;
        A_DS: n.rdata = s.ds;
        A_ES: n.rdata = s.es;
        A_SS: n.rdata = s.ss;
        A_RELOC: n.rdata = s.reloc;
        A_UMSEL: n.rdata = s.umsel;
        A_PRIO_A: n.rdata = s.prio_a;
        A_PRIO_B: n.rdata = s.prio_b;
        A_VBASE: n.rdata = s.vbase;
        A_VTYPE: n.rdata = {5'h00, s.st, s.vtype};
        A_PEND: n.rdata = {8'h00, s.nmi_pend, arb.pend};
        default: n.rdata = '0;
      endcase
    end

    case (s.st)
      ST_RESET: begin
        // Nothing runs until the internal delay after release.
        if (s.cnt == RST_DELAY_CYC) begin
          n.freq = 1'b1;
          n.st = ST_RUN;
        end else begin
          n.cnt = s.cnt + 4'h1;
        end
      end
      ST_RUN: begin
        if (boundary) begin
          n.ip = next_ip_i;
          n.sw = nsw;
          n.ret_ip = next_ip_i;
          if (exc | step | s.nmi_pend | take_irq) begin
            // Save first, then clear the enable and step flags.
            n.saved_sw = nsw;
            n.sw = nsw & ~SW_CLR_MASK;
            n.st = ST_PUSH_SW;
            if (exc) begin
              n.vtype = exc_type;
              if (exc_type == VT_COP) begin
                n.ret_ip = seg_prefix_i ? prefix_ip_i : instr_ip_i;
              end
            end else if (step) begin
              n.vtype = VT_STEP;
            end else if (s.nmi_pend) begin
              n.vtype = VT_NMI;
              n.nmi_pend = nmi_edge;
            end else begin
              n.vtype = arb.vtype;
              n.ack = arb.ack;
            end
          end
        end
      end
      ST_PUSH_SW: begin
        n.push = 1'b1;
        n.pdata = s.saved_sw;
        n.st = ST_PUSH_CS;
      end
      ST_PUSH_CS: begin
        n.push = 1'b1;
        n.pdata = s.cs;
        n.st = ST_PUSH_IP;
      end
      ST_PUSH_IP: begin
        n.push = 1'b1;
        n.pdata = s.ret_ip;
        n.st = ST_VECTOR;
      end
      ST_VECTOR: begin
        n.vreq = 1'b1;
        n.st = ST_RUN;
      end
      default: n.st = ST_RESET;
    endcase
  end

  // Reset constants cover every architectural register.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s <= RST_STATE;
    end else if (ce_i) begin
      s <= n;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // The core must not retire an instruction while a vector or restart loads.
  assign run_o = (s.st == ST_RUN) && !s.vreq && !s.freq;
  assign reg_rdata_o = s.rdata;
  assign src_ack_o = s.ack;
  assign push_o = s.push;
  assign push_data_o = s.pdata;
  assign vec_req_o = s.vreq;
  assign vec_type_o = s.vtype;
  assign vec_addr_o = vec_addr(s.vtype);
  assign fetch_req_o = s.freq;
  assign fetch_addr_o = 20'({s.cs, 4'h0} + {4'h0, s.ip});

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i || !ce_i);

  property p_restart;
    fetch_req_o |-> fetch_addr_o == RESTART_ADDR && s.cs == RST_CS && s.sw == RST_STATUS;
  endproperty
  a_restart: assert property (p_restart) else $error("restart address wrong");

  property p_quiet_reset;
    s.st == ST_RESET |-> !run_o && !push_o && !vec_req_o;
  endproperty
  a_quiet_reset: assert property (p_quiet_reset) else $error("activity in reset");

  property p_entry;
    s.st == ST_PUSH_SW |-> ##1 push_o && push_data_o == $past(s.saved_sw) ##1 push_o
      ##1 push_o ##1 vec_req_o;
  endproperty
  a_entry: assert property (p_entry) else $error("entry push order wrong");

  property p_vec_addr;
    vec_req_o |-> vec_addr_o == {vec_type_o, 2'b00};
  endproperty
  a_vec_addr: assert property (p_vec_addr) else $error("vector address wrong");

  property p_if_clear;
    boundary && (exc || step || s.nmi_pend || take_irq) |=> !s.sw[IF_BIT] && !s.sw[STEP_BIT]
      && s.saved_sw == $past(nsw);
  endproperty
  a_if_clear: assert property (p_if_clear) else $error("flags not cleared");

  property p_nmi;
    boundary && s.nmi_pend && !exc && !step |=> s.vtype == VT_NMI && src_ack_o == 9'h000;
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi entry wrong");

  property p_no_step;
    boundary && (prefix_i || seg_write_i || wait_i) && !exc && !s.nmi_pend && !take_irq
      |=> s.st == ST_RUN;
  endproperty
  a_no_step: assert property (p_no_step) else $error("step after excluded op");

  property p_cop;
    boundary && cop_op && !quot_ovf_i && !undef_i |=> s.vtype == VT_COP
      && s.ret_ip == ($past(seg_prefix_i) ? $past(prefix_ip_i) : $past(instr_ip_i));
  endproperty
  a_cop: assert property (p_cop) else $error("escape trap wrong");

  property p_masked;
    boundary && !nsw[IF_BIT] && !exc && !step && !s.nmi_pend |=> s.st == ST_RUN
      && src_ack_o == 9'h000;
  endproperty
  a_masked: assert property (p_masked) else $error("masked request taken");

endmodule : cpu_exception_vector_reset_unit

// ---- tb/req_source_model.sv ----
// Behavioural model of the maskable request sources: pins, DMA and timers.
// Assumes the bench pulses raise_i and the unit answers on ack_i.
`timescale 1ns/1ps
module req_source_model (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [8:0] raise_i,
  input wire logic [8:0] ack_i,
  output logic [2:0] tmr_req_o,
  output logic [1:0] dma_req_o,
  output logic [3:0] pins_o
);
  logic [8:0] held;

  // A source keeps its level until it is acknowledged, so a late service still sees it.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      held <= 9'h000;
    end else begin
      held <= (held & ~ack_i) | raise_i;
    end
  end

  assign {pins_o, dma_req_o, tmr_req_o} = held;
endmodule : req_source_model

// ---- tb/testbench.sv ----
// Self-checking bench for the exception, vector and reset unit.
// Assumes the package and the request source model are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end
module testbench import exc_pkg::*;;
  localparam logic [15:0] IIP = 16'h0100;
  localparam logic [15:0] PIP = 16'h00fe;
  localparam logic [15:0] NXT = 16'h0103;
  logic core_clk_i, rstn_i, ce_i, reg_wr_i, reg_rd_i, nmi_pin_i, instr_done_i;
  logic prefix_i, seg_write_i, wait_i, undef_i, brk_i, ovf_trap_i, range_chk_i;
  logic quot_ovf_i, seg_prefix_i, ret_instr_i, run_o, push_o, vec_req_o, fetch_req_o;
  logic [3:0] reg_addr_i, ext_request_pins_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, index_i, bound_lo_i, bound_hi_i, ret_sw_i;
  logic [15:0] instr_ip_i, prefix_ip_i, next_ip_i, push_data_o, sw_pushed;
  logic [2:0] tmr_req_i;
  logic [1:0] dma_req_i;
  logic [8:0] src_ack_o, raise, acks;
  logic [7:0] opcode_i, vec_type_o;
  logic [9:0] vec_addr_o, fl;
  logic [19:0] fetch_addr_o;
  int errors, compares, cycles;

  assign {seg_prefix_i, ret_instr_i, wait_i, seg_write_i, prefix_i, brk_i, ovf_trap_i,
    range_chk_i, undef_i, quot_ovf_i} = fl;

  cpu_exception_vector_reset_unit u_dut (.*);

  req_source_model u_src (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .raise_i(raise),
    .ack_i(src_ack_o),
    .tmr_req_o(tmr_req_i),
    .dma_req_o(dma_req_i),
    .pins_o(ext_request_pins_i)
  );

  always #5 core_clk_i = ~core_clk_i;

  // A hang is cut short long after the whole sequence should have ended.
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // Bus and instruction tasks
  // ----------------------------------------
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask : rd

  // Type ff means that no entry is expected at this boundary.
  task automatic step(input logic [9:0] f, input logic [7:0] op, input logic [7:0] et,
      input logic [15:0] eip);
    int n;
    logic [15:0] ret;
    logic [7:0] t;
    logic [9:0] va;
    n = 0;
    ret = eip;
    t = 8'hff;
    va = 10'h3fc;
    acks = 9'h000;
    #1;
    while (run_o !== 1'b1) begin
      @(posedge core_clk_i);
      #1;
    end
    @(posedge core_clk_i);
    fl <= f;
    opcode_i <= op;
    instr_done_i <= 1'b1;
    @(posedge core_clk_i);
    fl <= 10'h000;
    opcode_i <= 8'h90;
    instr_done_i <= 1'b0;
    repeat (8) begin
      #1;
      if (push_o === 1'b1) begin
        n++;
        ret = push_data_o;
        if (n == 1) sw_pushed = push_data_o;
      end
      if (vec_req_o === 1'b1) begin
        t = vec_type_o;
        va = vec_addr_o;
      end
      acks = acks | src_ack_o;
      @(posedge core_clk_i);
    end
    `CHK(n, (et == 8'hff) ? 0 : 3)
    `CHK(t, et)
    `CHK(va, {et, 2'b00})
    `CHK(ret, eip)
  endtask : step

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [15:0] exp [6];
    logic [15:0] d;
    int n;
    exp = '{16'hf002, 16'h0000, 16'hffff, 16'h0000, 16'h0000, 16'h0000};
    repeat (15) @(posedge core_clk_i);
    #1;
    `CHK(run_o, 1'b0)
    `CHK(fetch_req_o, 1'b0)
    @(posedge core_clk_i);
    rstn_i <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
      #1;
    end while (fetch_req_o !== 1'b1 && n < 20);
    `CHK(n, 7)
    `CHK(fetch_addr_o, 20'hffff0)
    for (int i = 0; i < 6; i++) begin
      rd(4'(i), d);
      `CHK(d, exp[i])
    end
    rd(A_RELOC, d);
    `CHK(d, 16'h20ff)
    rd(A_UMSEL, d);
    `CHK(d, 16'hfffb)
    rd(4'hd, d);
    `CHK(d, 16'h0000)
    $display("test reset done");
  endtask : t_reset

  task automatic t_exc();
    logic [15:0] d;
    step(10'h003, 8'h90, 8'h00, NXT);
    step(10'h002, 8'h90, 8'h06, NXT);
    step(10'h004, 8'h90, 8'h05, NXT);
    @(posedge core_clk_i);
    index_i <= 16'h0005;
    step(10'h004, 8'h90, 8'hff, NXT);
    wr(A_STATUS, 16'hf202);
    step(10'h010, 8'h90, 8'h03, NXT);
    `CHK(sw_pushed, 16'hf202)
    rd(A_STATUS, d);
    `CHK(d[IF_BIT], 1'b0)
    wr(A_STATUS, 16'hf802);
    step(10'h008, 8'h90, 8'h04, NXT);
    wr(A_STATUS, 16'hf002);
    step(10'h008, 8'h90, 8'hff, NXT);
    for (int i = 0; i < 8; i++) step(10'h000, 8'hd8 + 8'(i), 8'h07, IIP);
    step(10'h200, 8'hdb, 8'h07, PIP);
    $display("test exceptions done");
  endtask : t_exc

  task automatic t_step();
    logic [15:0] d;
    wr(A_STATUS, 16'hf102);
    step(10'h000, 8'h90, 8'h01, NXT);
    rd(A_STATUS, d);
    `CHK(d[STEP_BIT], 1'b0)
    wr(A_STATUS, 16'hf102);
    for (int i = 0; i < 3; i++) step(10'h020 << i, 8'h90, 8'hff, NXT);
    wr(A_STATUS, 16'hf002);
    ret_sw_i <= 16'hf102;
    step(10'h100, 8'h90, 8'hff, NXT);
    step(10'h000, 8'h90, 8'h01, NXT);
    $display("test single step done");
  endtask : t_step

  task automatic t_nmi();
    logic [15:0] d;
    for (int i = 0; i < 2; i++) begin
      wr(A_STATUS, i[0] ? 16'hf202 : 16'hf002);
      nmi_pin_i <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      nmi_pin_i <= 1'b0;
      repeat (4) @(posedge core_clk_i);
      step(10'h000, 8'h90, 8'h02, NXT);
      `CHK(acks, 9'h000)
      rd(A_STATUS, d);
      `CHK(d[IF_BIT], 1'b0)
    end
    $display("test nmi done");
  endtask : t_nmi

  task automatic t_mask();
    logic [7:0] vt [5];
    logic [8:0] ak [5];
    vt = '{8'h08, 8'h12, 8'h13, 8'h0a, 8'h0f};
    ak = '{9'h001, 9'h002, 9'h004, 9'h008, 9'h100};
    wr(A_STATUS, 16'hf002);
    raise <= 9'h00f;
    @(posedge core_clk_i);
    raise <= 9'h000;
    step(10'h000, 8'h90, 8'hff, NXT);
    `CHK(acks, 9'h000)
    for (int i = 0; i < 5; i++) begin
      if (i == 4) raise <= 9'h100;
      wr(A_STATUS, 16'hf202);
      raise <= 9'h000;
      repeat (4) @(posedge core_clk_i);
      step(10'h000, 8'h90, vt[i], NXT);
      `CHK(acks, ak[i])
    end
    $display("test maskable done");
  endtask : t_mask

  task automatic t_return();
    @(posedge core_clk_i);
    raise <= 9'h020;
    ret_sw_i <= 16'hf202;
    @(posedge core_clk_i);
    raise <= 9'h000;
    repeat (4) @(posedge core_clk_i);
    step(10'h100, 8'h90, 8'h0c, NXT);
    `CHK(acks, 9'h020)
    $display("test return done");
  endtask : t_return

  // Unique levels, dma1 on top, and slave mode with programmed vector bases.
  task automatic t_prio();
    logic [15:0] d;
    wr(A_PRIO_A, 16'h0611);
    wr(A_PRIO_B, 16'h81ac);
    wr(A_VBASE, 16'h5040);
    raise <= 9'h019;
    wr(A_STATUS, 16'hf202);
    raise <= 9'h000;
    rd(A_PEND, d);
    `CHK(d, 16'h0007)
    step(10'h000, 8'h90, 8'h51, NXT);
    `CHK(acks, 9'h010)
    rd(A_VTYPE, d);
    `CHK(d, 16'h0151)
    wr(A_STATUS, 16'hf202);
    step(10'h000, 8'h90, 8'h40, NXT);
    `CHK(acks, 9'h001)
    wr(A_STATUS, 16'hf202);
    step(10'h000, 8'h90, 8'h50, NXT);
    `CHK(acks, 9'h008)
    $display("test priority done");
  endtask : t_prio

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    core_clk_i = 1'b0;
    rstn_i = 1'b0;
    ce_i = 1'b1;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 4'h0;
    reg_wdata_i = 16'h0000;
    nmi_pin_i = 1'b0;
    instr_done_i = 1'b0;
    fl = 10'h000;
    opcode_i = 8'h90;
    raise = 9'h000;
    index_i = 16'h0010;
    bound_lo_i = 16'h0000;
    bound_hi_i = 16'h000f;
    ret_sw_i = 16'hf002;
    instr_ip_i = IIP;
    prefix_ip_i = PIP;
    next_ip_i = NXT;
    t_reset();
    t_exc();
    t_step();
    t_nmi();
    t_mask();
    t_return();
    t_prio();
    report_and_stop();
  end
endmodule : testbench
